// ---- verilog/pmc_pkg.sv ----
// Purpose: shared constants and types of the programming mode controller
// Assumes: one 40 MHz clock shared by the device end and the programmer end
// Notes: the link carries abstract commands, not the serial byte protocols
//
// Contract
// - reset pin held 5.1 ms enters programming mode
// - power-on or restart command gives normal mode
// - firmware flag or cleared lock enables auto mode
// - control command in programming mode starts RAM execution
// - lower 2 kB buffer; whole 4 kB code
// - both external RAMs readable and writable
// - internal and critical RAMs are denied
// - code flash is 64 equal erase sectors
// - 255-byte data area reached through commands only
// - config area holds locks, reached by commands
// - set locks block read-back, RAM run, sector erase
// - processor flash access ignores the locks
// - on-chip CRC-32 checked against top four bytes
// - fixed signature readable over SPI
// - pin entry works with blank flash
// - programmer without pin relies on firmware auto mode
// - programmer programs code and config areas first
// - programmer writes calibration into config area once
// - enable command after hold selects SPI or UART; USB only after auto mode entry
// - auto mode: internal reset request or short pin pulse boots into programming
// - power cycle or command clears auto flag
// - only full-chip erase sets the auto lock
package pmc_pkg;
	localparam int unsigned CLK_MHZ = 40;
	localparam int unsigned ENTRY_TIME_US = 5100; // 5.1 ms
	localparam int unsigned ENTRY_CYCLES = ENTRY_TIME_US * CLK_MHZ;
	localparam int unsigned ENTRY_MARGIN = 64;
	localparam int unsigned PULSE_CYCLES = 16;
	localparam int unsigned CNT_W = 18;
	localparam logic [16:0] FLASH_LAST = 17'h1ffff;
	localparam logic [16:0] CRC_ADDR = 17'h1fffc;
	localparam int unsigned SECTORS = 64;
	localparam int unsigned SECT_W = 6;
	localparam logic [16:0] XRAM4_BYTES = 17'h01000;
	localparam logic [16:0] BUF_BYTES = 17'h00800;
	localparam logic [16:0] XRAM12_BYTES = 17'h03000;
	localparam logic [16:0] DATA_BYTES = 17'h000ff;
	localparam logic [16:0] CFG_BYTES = 17'h00100;
	localparam logic [31:0] CRC_POLY = 32'hedb88320;
	localparam logic [31:0] CRC_INIT = 32'hffffffff;
	localparam logic [55:0] SIG_DEFAULT = 56'h0123456789abcd; // arbitrary value
	localparam int unsigned PROT_READ = 0;
	localparam int unsigned PROT_RAMX = 1;
	localparam int unsigned PROT_ERASE = 2;
	localparam int unsigned PROT_W = 3;
	localparam logic [7:0] OP_ENABLE = 8'h01;
	localparam logic [7:0] OP_READ = 8'h10;
	localparam logic [7:0] OP_WRITE = 8'h11;
	localparam logic [7:0] OP_ERASE_SECTOR = 8'h20;
	localparam logic [7:0] OP_ERASE_CHIP = 8'h21;
	localparam logic [7:0] OP_PROG_SECTOR = 8'h22;
	localparam logic [7:0] OP_SET_LOCK = 8'h30;
	localparam logic [7:0] OP_READ_LOCK = 8'h31;
	localparam logic [7:0] OP_CLR_APM_LOCK = 8'h32;
	localparam logic [7:0] OP_CLR_AUTO_PROGRAM_FLAG = 8'h33;
	localparam logic [7:0] OP_EXEC_RAM = 8'h40;
	localparam logic [7:0] OP_RESET_CHIP = 8'h41;
	localparam logic [7:0] OP_CRC_CHECK = 8'h50;
	localparam logic [7:0] OP_READ_SIG = 8'h60;
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_STATUS = 8'h04;
	localparam logic [7:0] REG_CMD = 8'h08;
	localparam logic [7:0] REG_ADDR = 8'h0c;
	localparam logic [7:0] REG_DATA = 8'h10;
	localparam logic [7:0] REG_RSP = 8'h14;
	localparam int unsigned CTRL_ENTER = 0;
	localparam int unsigned CTRL_PULSE = 1;
	localparam int unsigned CTRL_ABORT = 2;
	localparam int unsigned STAT_HOLD = 0;
	localparam int unsigned STAT_BUSY = 1;
	localparam int unsigned STAT_OK = 2;
	localparam int unsigned CMD_OP_LSB = 0;
	localparam int unsigned CMD_SP_LSB = 8;
	localparam int unsigned CMD_IF_LSB = 12;
	localparam logic [31:0] REG_RESET = 32'h00000000;
	localparam logic [1:0] AXI_OKAY = 2'h0;
	localparam logic [1:0] AXI_SLVERR = 2'h2;

	typedef enum logic [1:0] {MODE_NORMAL, MODE_PROG, MODE_AUTO, MODE_RAMEXEC} pmc_mode_e;
	typedef enum logic [1:0] {IF_SPI, IF_UART, IF_USB, IF_NONE} pmc_if_e;
	typedef enum logic [2:0] {SP_FLASH, SP_XRAM4, SP_XRAM12, SP_INTERNAL_DATA_RAM, SP_CRIT, SP_DATA,
		SP_CFG} pmc_space_e;
	typedef enum logic [2:0] {MOP_READ, MOP_WRITE, MOP_ERASE_SECTOR, MOP_ERASE_ALL,
		MOP_PROG_SECTOR} pmc_mop_e;

	// one reflected crc-32 step over a byte
	function automatic logic [31:0] pmc_crc_byte(input logic [31:0] c, input logic [7:0] d);
		logic [31:0] r;
		r = c ^ {24'h000000, d};
		for (int i = 0; i < 8; i++) begin
			r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
		end
		return r;
	endfunction
endpackage

// ---- verilog/pmc_link.sv ----
`timescale 1ns/1ps
// Purpose: link between programmer and device, one modport per end
// Assumes: both ends on ref_clk
// Notes: reset pin modeled as a plain level driven by the programmer
interface pmc_link;
	logic rstnPin;
	logic cmdValid;
	logic cmdReady;
	pmc_pkg::pmc_if_e cmdIf;
	logic [7:0] cmdOp;
	pmc_pkg::pmc_space_e cmdSpace;
	logic [16:0] cmdAddr;
	logic [7:0] cmdData;
	logic rspValid;
	logic rspOk;
	logic [31:0] rspData;
	modport dev(input rstnPin, cmdValid, cmdIf, cmdOp, cmdSpace, cmdAddr, cmdData,
		output cmdReady, rspValid, rspOk, rspData);
	modport prog(output rstnPin, cmdValid, cmdIf, cmdOp, cmdSpace, cmdAddr, cmdData,
		input cmdReady, rspValid, rspOk, rspData);
endinterface

// ---- verilog/pmc_device.sv ----
`timescale 1ns/1ps
// Purpose: device end, mode selection, access policing, crc check
// Assumes: reset pin level on the link is synchronous to ref_clk
// Notes: flash, rams and nonvolatile areas sit behind the mem port
module pmc_device #(
	parameter int unsigned ENTRY_CYC = pmc_pkg::ENTRY_CYCLES,
	parameter logic [55:0] SIGNATURE = pmc_pkg::SIG_DEFAULT
) (
	input logic ref_clk,
	input logic rstn,
	input logic ce,
	pmc_link.dev lnk,
	input logic fwAutoProgSet,
	input logic intRstReq,
	input logic [pmc_pkg::PROT_W-1:0] nvProtectIn,
	input logic nvApmLockIn,
	output logic memReq,
	output pmc_pkg::pmc_mop_e memOp,
	output pmc_pkg::pmc_space_e memSpace,
	output logic [16:0] memAddr,
	output logic [7:0] memWdata,
	input logic [7:0] memRdata,
	input logic memAck,
	output pmc_pkg::pmc_mode_e mode,
	output pmc_pkg::pmc_if_e progIf,
	output logic cpuRun,
	output logic cpuFetchRam,
	output logic cpuFlashEn,
	output logic [pmc_pkg::PROT_W-1:0] nvProtect,
	output logic nvApmLock,
	output logic auto_program_flag
);
	import pmc_pkg::*;

	if (ENTRY_CYC < 2 || ENTRY_CYC >= (1 << CNT_W)) begin : g_chk
		$error("ENTRY_CYC out of range");
	end

	typedef enum logic [2:0] {ST_NORMAL, ST_RST_HOLD, ST_WAIT_IF, ST_IDLE, ST_MEM,
		ST_CRC_DATA, ST_CRC_TAIL, ST_RAM_EXEC} pmc_state_e;

	pmc_state_e state_ff, nxt_state;
	logic [CNT_W-1:0] holdCnt_ff, nxt_holdCnt;
	pmc_if_e progIf_ff, nxt_progIf;
	logic viaApm_ff, nxt_viaApm;
	logic loaded_ff, nxt_loaded;
	logic [PROT_W-1:0] prot_ff, nxt_prot;
	logic apmLock_ff, nxt_apmLock;
	logic auto_program_flag_ff, nxt_auto_program_flag;
	pmc_mop_e memOp_ff, nxt_memOp;
	pmc_space_e memSpace_ff, nxt_memSpace;
	logic [16:0] memAddr_ff, nxt_memAddr;
	logic [7:0] memWdata_ff, nxt_memWdata;
	logic [31:0] crc_ff, nxt_crc;
	logic [31:0] stored_ff, nxt_stored;
	logic rspValid_ff, nxt_rspValid;
	logic rspOk_ff, nxt_rspOk;
	logic [31:0] rspData_ff, nxt_rspData;
	logic apmOn, take, mine, clrAuto;

	// range check of a memory access by space
	function automatic logic accOk(input pmc_space_e sp, input logic [16:0] a,
		input logic wr, input logic rdProt);
		unique case (sp)
			SP_FLASH: accOk = !wr && !rdProt;
			SP_XRAM4: accOk = a < XRAM4_BYTES;
			SP_XRAM12: accOk = a < XRAM12_BYTES;
			SP_DATA: accOk = a < DATA_BYTES;
			SP_CFG: accOk = a < CFG_BYTES;
			default: accOk = 1'b0;
		endcase
	endfunction

	// auto mode from firmware flag or cleared lock
	assign apmOn = auto_program_flag_ff || !apmLock_ff;
	// commands are only taken in states that can act on them
	assign lnk.cmdReady = ce && lnk.rstnPin &&
		(state_ff == ST_WAIT_IF || state_ff == ST_IDLE || state_ff == ST_RAM_EXEC);
	assign take = lnk.cmdValid && lnk.cmdReady;
	assign mine = lnk.cmdIf == progIf_ff;

	// next-state logic for the whole controller
	always_comb begin
		nxt_state = state_ff;
		nxt_holdCnt = '0;
		nxt_progIf = progIf_ff;
		nxt_viaApm = viaApm_ff;
		nxt_loaded = 1'b1;
		nxt_prot = prot_ff;
		nxt_apmLock = apmLock_ff;
		nxt_memOp = memOp_ff;
		nxt_memSpace = memSpace_ff;
		nxt_memAddr = memAddr_ff;
		nxt_memWdata = memWdata_ff;
		nxt_crc = crc_ff;
		nxt_stored = stored_ff;
		nxt_rspValid = 1'b0;
		nxt_rspOk = rspOk_ff;
		nxt_rspData = rspData_ff;
		clrAuto = 1'b0;
		// nonvolatile locks are copied once after reset release
		if (!loaded_ff) begin
			nxt_prot = nvProtectIn;
			nxt_apmLock = nvApmLockIn;
		end
		if (!lnk.rstnPin) begin
			nxt_state = ST_RST_HOLD;
			nxt_progIf = IF_NONE;
			if (state_ff == ST_RST_HOLD && holdCnt_ff < CNT_W'(ENTRY_CYC)) begin
				nxt_holdCnt = holdCnt_ff + 1'b1;
			end else if (state_ff == ST_RST_HOLD) begin
				nxt_holdCnt = holdCnt_ff;
			end
		end else begin
			unique case (state_ff)
				ST_NORMAL: begin
					if (intRstReq && apmOn) begin
						nxt_state = ST_WAIT_IF;
						nxt_viaApm = 1'b1;
					end
				end
				ST_RST_HOLD: begin
					// entry never looks at flash contents
					if (holdCnt_ff >= CNT_W'(ENTRY_CYC - 1)) begin
						nxt_state = ST_WAIT_IF;
						nxt_viaApm = 1'b0;
					end else if (apmOn) begin
						nxt_state = ST_WAIT_IF;
						nxt_viaApm = 1'b1;
					end else begin
						nxt_state = ST_NORMAL;
					end
				end
				ST_WAIT_IF: begin
					if (take && lnk.cmdOp == OP_ENABLE && lnk.cmdIf != IF_NONE &&
						(lnk.cmdIf != IF_USB || viaApm_ff)) begin
						nxt_progIf = lnk.cmdIf;
						nxt_state = ST_IDLE;
						nxt_rspValid = 1'b1;
						nxt_rspOk = 1'b1;
						nxt_rspData = '0;
					end
				end
				ST_IDLE: begin
					if (take && mine) begin
						nxt_rspValid = 1'b1;
						nxt_rspOk = 1'b1;
						nxt_rspData = '0;
						nxt_memSpace = lnk.cmdSpace;
						nxt_memAddr = lnk.cmdAddr;
						nxt_memWdata = lnk.cmdData;
						unique case (lnk.cmdOp)
							OP_READ, OP_WRITE: begin
								if (accOk(lnk.cmdSpace, lnk.cmdAddr, lnk.cmdOp == OP_WRITE,
									prot_ff[PROT_READ])) begin
									nxt_rspValid = 1'b0;
									nxt_memOp = (lnk.cmdOp == OP_WRITE) ? MOP_WRITE : MOP_READ;
									nxt_state = ST_MEM;
								end else begin
									nxt_rspOk = 1'b0;
								end
							end
							OP_ERASE_SECTOR, OP_PROG_SECTOR: begin
								// sector index in the low address bits
								nxt_memSpace = SP_FLASH;
								nxt_memAddr = {11'h000, lnk.cmdAddr[SECT_W-1:0]};
								if (lnk.cmdOp == OP_ERASE_SECTOR && prot_ff[PROT_ERASE]) begin
									nxt_rspOk = 1'b0;
								end else begin
									nxt_rspValid = 1'b0;
									// program copies the lower half buffer of the 4 kB ram
									nxt_memOp = (lnk.cmdOp == OP_ERASE_SECTOR) ?
										MOP_ERASE_SECTOR : MOP_PROG_SECTOR;
									nxt_state = ST_MEM;
								end
							end
							OP_ERASE_CHIP: begin
								nxt_rspValid = 1'b0;
								nxt_memSpace = SP_FLASH;
								nxt_memOp = MOP_ERASE_ALL;
								nxt_apmLock = 1'b1;
								nxt_state = ST_MEM;
							end
							// protection locks only ever get set, never cleared here
							OP_SET_LOCK: nxt_prot = prot_ff | lnk.cmdData[PROT_W-1:0];
							OP_READ_LOCK: nxt_rspData = {27'h0000000, prot_ff, apmLock_ff,
								auto_program_flag_ff};
							OP_CLR_APM_LOCK: nxt_apmLock = 1'b0;
							OP_CLR_AUTO_PROGRAM_FLAG: clrAuto = 1'b1;
							OP_EXEC_RAM: begin
								if (prot_ff[PROT_RAMX]) begin
									nxt_rspOk = 1'b0;
								end else begin
									nxt_state = ST_RAM_EXEC;
								end
							end
							OP_RESET_CHIP: begin
								nxt_state = ST_NORMAL;
								nxt_progIf = IF_NONE;
							end
							OP_CRC_CHECK: begin
								nxt_rspValid = 1'b0;
								nxt_crc = CRC_INIT;
								nxt_memSpace = SP_FLASH;
								nxt_memOp = MOP_READ;
								nxt_memAddr = '0;
								nxt_state = ST_CRC_DATA;
							end
							OP_READ_SIG: begin
								if (progIf_ff == IF_SPI && lnk.cmdAddr[2:0] != 3'h7) begin
									nxt_rspData = {24'h000000,
										SIGNATURE[8 * (6 - int'(lnk.cmdAddr[2:0])) +: 8]};
								end else begin
									nxt_rspOk = 1'b0;
								end
							end
							default: nxt_rspOk = 1'b0;
						endcase
					end
				end
				ST_MEM: begin
					if (memAck) begin
						nxt_rspValid = 1'b1;
						nxt_rspOk = 1'b1;
						nxt_rspData = {24'h000000, memRdata};
						nxt_state = ST_IDLE;
					end
				end
				ST_CRC_DATA: begin
					if (memAck) begin
						nxt_crc = pmc_crc_byte(crc_ff, memRdata);
						nxt_memAddr = memAddr_ff + 17'h00001;
						if (memAddr_ff == CRC_ADDR - 17'h00001) begin
							nxt_state = ST_CRC_TAIL;
						end
					end
				end
				ST_CRC_TAIL: begin
					// stored checksum is little endian from the lowest address
					if (memAck) begin
						nxt_stored = {memRdata, stored_ff[31:8]};
						nxt_memAddr = memAddr_ff + 17'h00001;
						if (memAddr_ff == FLASH_LAST) begin
							nxt_rspValid = 1'b1;
							nxt_rspData = ~crc_ff;
							nxt_rspOk = {memRdata, stored_ff[31:8]} == ~crc_ff;
							nxt_state = ST_IDLE;
						end
					end
				end
				ST_RAM_EXEC: begin
					// the cpu owns the ram, only a restart is honoured
					if (take && mine && lnk.cmdOp == OP_RESET_CHIP) begin
						nxt_state = ST_NORMAL;
						nxt_progIf = IF_NONE;
					end
				end
				default: nxt_state = ST_NORMAL;
			endcase
		end
		// firmware set wins over a clear in the same cycle
		nxt_auto_program_flag = fwAutoProgSet ? 1'b1 : (clrAuto ? 1'b0 : auto_program_flag_ff);
	end

	// registers; power-on reset clears the auto flag
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			state_ff <= ST_NORMAL;
			holdCnt_ff <= '0;
			progIf_ff <= IF_NONE;
			viaApm_ff <= 1'b0;
			loaded_ff <= 1'b0;
			prot_ff <= '0;
			apmLock_ff <= 1'b1;
			auto_program_flag_ff <= 1'b0;
			memOp_ff <= MOP_READ;
			memSpace_ff <= SP_FLASH;
			memAddr_ff <= '0;
			memWdata_ff <= '0;
			crc_ff <= CRC_INIT;
			stored_ff <= '0;
			rspValid_ff <= 1'b0;
			rspOk_ff <= 1'b0;
			rspData_ff <= '0;
		end else if (ce) begin
			state_ff <= nxt_state;
			holdCnt_ff <= nxt_holdCnt;
			progIf_ff <= nxt_progIf;
			viaApm_ff <= nxt_viaApm;
			loaded_ff <= nxt_loaded;
			prot_ff <= nxt_prot;
			apmLock_ff <= nxt_apmLock;
			auto_program_flag_ff <= nxt_auto_program_flag;
			memOp_ff <= nxt_memOp;
			memSpace_ff <= nxt_memSpace;
			memAddr_ff <= nxt_memAddr;
			memWdata_ff <= nxt_memWdata;
			crc_ff <= nxt_crc;
			stored_ff <= nxt_stored;
			rspValid_ff <= nxt_rspValid;
			rspOk_ff <= nxt_rspOk;
			rspData_ff <= nxt_rspData;
		end
	end

	// outputs
	assign memReq = ce && lnk.rstnPin &&
		(state_ff == ST_MEM || state_ff == ST_CRC_DATA || state_ff == ST_CRC_TAIL);
	assign memOp = memOp_ff;
	assign memSpace = memSpace_ff;
	assign memAddr = memAddr_ff;
	assign memWdata = memWdata_ff;
	assign lnk.rspValid = rspValid_ff && ce;
	assign lnk.rspOk = rspOk_ff;
	assign lnk.rspData = rspData_ff;
	assign mode = (state_ff == ST_NORMAL || state_ff == ST_RST_HOLD) ? MODE_NORMAL :
		(state_ff == ST_RAM_EXEC) ? MODE_RAMEXEC : (viaApm_ff ? MODE_AUTO : MODE_PROG);
	assign progIf = progIf_ff;
	assign cpuRun = state_ff == ST_NORMAL || state_ff == ST_RAM_EXEC;
	assign cpuFetchRam = state_ff == ST_RAM_EXEC;
	// locks deliberately not in this term
	assign cpuFlashEn = state_ff == ST_NORMAL;
	assign nvProtect = prot_ff;
	assign nvApmLock = apmLock_ff;
	assign auto_program_flag = auto_program_flag_ff;
endmodule

// ---- verilog/pmc_programmer.sv ----
`timescale 1ns/1ps
// Purpose: programmer end, AXI4-Lite registers driving the link
// Assumes: software sequences enable, commands and restart
// Notes: one command outstanding; abort frees a command that got no answer
module pmc_programmer #(
	parameter int unsigned HOLD_CYC = pmc_pkg::ENTRY_CYCLES + pmc_pkg::ENTRY_MARGIN,
	parameter int unsigned PULSE_CYC = pmc_pkg::PULSE_CYCLES,
	parameter int unsigned AW = 8
) (
	input logic ref_clk,
	input logic rstn,
	input logic ce,
	pmc_link.prog lnk,
	input logic [AW-1:0] s_awaddr,
	input logic s_awvalid,
	output logic s_awready,
	input logic [31:0] s_wdata,
	input logic [3:0] s_wstrb,
	input logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input logic s_bready,
	input logic [AW-1:0] s_araddr,
	input logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input logic s_rready
);
	import pmc_pkg::*;

	if (AW < 5 || AW > 8 || HOLD_CYC < 2 || HOLD_CYC >= (1 << CNT_W) || PULSE_CYC < 1 ||
		PULSE_CYC >= HOLD_CYC) begin : g_chk
		$error("pmc_programmer parameters out of range");
	end

	logic awHave_ff, nxt_awHave, wHave_ff, nxt_wHave;
	logic [7:0] awAddr_ff, nxt_awAddr;
	logic [31:0] wData_ff, nxt_wData;
	logic [3:0] wStrb_ff, nxt_wStrb;
	logic bvalid_ff, nxt_bvalid, rvalid_ff, nxt_rvalid;
	logic [1:0] bresp_ff, nxt_bresp, rresp_ff, nxt_rresp;
	logic [31:0] rdata_ff, nxt_rdata;
	logic [31:0] cmd_ff, nxt_cmd, addr_ff, nxt_addr, data_ff, nxt_data, rsp_ff, nxt_rsp;
	logic busy_ff, nxt_busy, ok_ff, nxt_ok, cmdValid_ff, nxt_cmdValid;
	logic [CNT_W-1:0] holdCnt_ff, nxt_holdCnt;
	logic rstnPin_ff, nxt_rstnPin;
	logic [31:0] wMask;

	assign wMask = {{8{wStrb_ff[3]}}, {8{wStrb_ff[2]}}, {8{wStrb_ff[1]}}, {8{wStrb_ff[0]}}};
	assign s_awready = ce && !awHave_ff && !bvalid_ff;
	assign s_wready = ce && !wHave_ff && !bvalid_ff;
	assign s_arready = ce && !rvalid_ff;

	// bus slave, command launch and reset pin sequencing
	always_comb begin
		nxt_awHave = awHave_ff;
		nxt_wHave = wHave_ff;
		nxt_awAddr = awAddr_ff;
		nxt_wData = wData_ff;
		nxt_wStrb = wStrb_ff;
		nxt_bvalid = bvalid_ff && !s_bready;
		nxt_bresp = bresp_ff;
		nxt_rvalid = rvalid_ff && !s_rready;
		nxt_rresp = rresp_ff;
		nxt_rdata = rdata_ff;
		nxt_cmd = cmd_ff;
		nxt_addr = addr_ff;
		nxt_data = data_ff;
		nxt_rsp = rsp_ff;
		nxt_busy = busy_ff;
		nxt_ok = ok_ff;
		nxt_cmdValid = cmdValid_ff && !lnk.cmdReady;
		nxt_holdCnt = (holdCnt_ff != '0) ? holdCnt_ff - 1'b1 : holdCnt_ff;
		if (busy_ff && lnk.rspValid) begin
			nxt_busy = 1'b0;
			nxt_ok = lnk.rspOk;
			nxt_rsp = lnk.rspData;
		end
		if (s_awvalid && s_awready) begin
			nxt_awHave = 1'b1;
			nxt_awAddr = {s_awaddr[AW-1:2], 2'b00};
		end
		if (s_wvalid && s_wready) begin
			nxt_wHave = 1'b1;
			nxt_wData = s_wdata;
			nxt_wStrb = s_wstrb;
		end
		// both halves in hand, either arrival order
		if (awHave_ff && wHave_ff) begin
			nxt_awHave = 1'b0;
			nxt_wHave = 1'b0;
			nxt_bvalid = 1'b1;
			nxt_bresp = AXI_OKAY;
			unique case (awAddr_ff)
				REG_CTRL: begin
					if (wStrb_ff[0] && wData_ff[CTRL_ENTER]) begin
						nxt_holdCnt = CNT_W'(HOLD_CYC);
						nxt_busy = 1'b0;
						nxt_cmdValid = 1'b0;
					end else if (wStrb_ff[0] && wData_ff[CTRL_PULSE]) begin
						// short pulse boots via auto mode when enabled
						nxt_holdCnt = CNT_W'(PULSE_CYC);
					end
					if (wStrb_ff[0] && wData_ff[CTRL_ABORT]) begin
						nxt_busy = 1'b0;
						nxt_cmdValid = 1'b0;
					end
				end
				REG_CMD: begin
					// a write while busy is dropped, status shows busy
					if (!busy_ff) begin
						nxt_cmd = (cmd_ff & ~wMask) | (wData_ff & wMask);
						nxt_cmdValid = 1'b1;
						nxt_busy = 1'b1;
					end
				end
				REG_ADDR: nxt_addr = (addr_ff & ~wMask) | (wData_ff & wMask);
				REG_DATA: nxt_data = (data_ff & ~wMask) | (wData_ff & wMask);
				REG_STATUS, REG_RSP: nxt_bresp = AXI_OKAY;
				default: nxt_bresp = AXI_SLVERR;
			endcase
		end
		if (s_arvalid && s_arready) begin
			nxt_rvalid = 1'b1;
			nxt_rresp = AXI_OKAY;
			unique case ({s_araddr[AW-1:2], 2'b00})
				REG_CTRL: nxt_rdata = '0;
				REG_STATUS: nxt_rdata = {29'h00000000, ok_ff, busy_ff, holdCnt_ff != '0};
				REG_CMD: nxt_rdata = {18'h00000, cmd_ff[13:0]};
				REG_ADDR: nxt_rdata = {15'h0000, addr_ff[16:0]};
				REG_DATA: nxt_rdata = {24'h000000, data_ff[7:0]};
				REG_RSP: nxt_rdata = rsp_ff;
				default: begin
					nxt_rdata = '0;
					nxt_rresp = AXI_SLVERR;
				end
			endcase
		end
		nxt_rstnPin = nxt_holdCnt == '0;
	end

	// registers
	always_ff @(posedge ref_clk or negedge rstn) begin
		if (!rstn) begin
			awHave_ff <= 1'b0;
			wHave_ff <= 1'b0;
			awAddr_ff <= '0;
			wData_ff <= '0;
			wStrb_ff <= '0;
			bvalid_ff <= 1'b0;
			bresp_ff <= AXI_OKAY;
			rvalid_ff <= 1'b0;
			rresp_ff <= AXI_OKAY;
			rdata_ff <= '0;
			cmd_ff <= REG_RESET;
			addr_ff <= REG_RESET;
			data_ff <= REG_RESET;
			rsp_ff <= REG_RESET;
			busy_ff <= 1'b0;
			ok_ff <= 1'b0;
			cmdValid_ff <= 1'b0;
			holdCnt_ff <= '0;
			rstnPin_ff <= 1'b1;
		end else if (ce) begin
			awHave_ff <= nxt_awHave;
			wHave_ff <= nxt_wHave;
			awAddr_ff <= nxt_awAddr;
			wData_ff <= nxt_wData;
			wStrb_ff <= nxt_wStrb;
			bvalid_ff <= nxt_bvalid;
			bresp_ff <= nxt_bresp;
			rvalid_ff <= nxt_rvalid;
			rresp_ff <= nxt_rresp;
			rdata_ff <= nxt_rdata;
			cmd_ff <= nxt_cmd;
			addr_ff <= nxt_addr;
			data_ff <= nxt_data;
			rsp_ff <= nxt_rsp;
			busy_ff <= nxt_busy;
			ok_ff <= nxt_ok;
			cmdValid_ff <= nxt_cmdValid;
			holdCnt_ff <= nxt_holdCnt;
			rstnPin_ff <= nxt_rstnPin;
		end
	end

	// outputs
	assign s_bvalid = bvalid_ff;
	assign s_bresp = bresp_ff;
	assign s_rvalid = rvalid_ff;
	assign s_rresp = rresp_ff;
	assign s_rdata = rdata_ff;
	assign lnk.rstnPin = rstnPin_ff;
	assign lnk.cmdValid = cmdValid_ff;
	assign lnk.cmdOp = cmd_ff[CMD_OP_LSB +: 8];
	assign lnk.cmdSpace = pmc_space_e'(cmd_ff[CMD_SP_LSB +: 3]);
	assign lnk.cmdIf = pmc_if_e'(cmd_ff[CMD_IF_LSB +: 2]);
	assign lnk.cmdAddr = addr_ff[16:0];
	assign lnk.cmdData = data_ff[7:0];
endmodule

// ---- verif/pmc_link_properties.sv ----
// Purpose: link checks between the two ends
// Assumes: one clock, rstn active low
// Notes: a dropped command passes as a refusal
`timescale 1ns/1ps
module pmc_link_properties (
	input logic ref_clk,
	input logic rstn,
	input logic rstnPin,
	input logic cmdValid,
	input logic cmdReady,
	input pmc_pkg::pmc_if_e cmdIf,
	input logic [7:0] cmdOp,
	input pmc_pkg::pmc_space_e cmdSpace,
	input logic [16:0] cmdAddr,
	input logic rspValid,
	input logic rspOk
);
	import pmc_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rstn);
	// command taken, then no good answer
	sequence s_take(o, s);
		cmdValid && cmdReady && cmdOp == o && cmdSpace == s;
	endsequence
	sequence s_bad;
		!(rspValid && rspOk);
	endsequence
	property p_pulse; rspValid |=> !rspValid; endproperty
	a_pulse: assert property (p_pulse) else $error("answer too long");
	property p_rise; $rose(rstnPin) |-> !cmdReady; endproperty
	a_rise: assert property (p_rise) else $error("ready at pin release");
	property p_held; !rstnPin |-> !cmdReady; endproperty
	a_held: assert property (p_held) else $error("ready with pin low");
	property p_hold; cmdValid && !cmdReady |=> $stable(cmdOp) && $stable(cmdAddr); endproperty
	a_hold: assert property (p_hold) else $error("command moved");
	property p_internal_data_ram; s_take(OP_READ, SP_INTERNAL_DATA_RAM) |=> s_bad; endproperty
	a_internal_data_ram: assert property (p_internal_data_ram) else $error("internal_data_ram open");
	property p_crit; s_take(OP_READ, SP_CRIT) |=> s_bad; endproperty
	a_crit: assert property (p_crit) else $error("critical ram open");
	property p_sig; cmdValid && cmdReady && cmdOp == OP_READ_SIG && cmdIf != IF_SPI |=> s_bad;
	endproperty
	a_sig: assert property (p_sig) else $error("signature off spi");
	property p_range; s_take(OP_READ, SP_XRAM12) ##0 cmdAddr >= XRAM12_BYTES |=> s_bad;
	endproperty
	a_range: assert property (p_range) else $error("ram range");
endmodule

// ---- verif/programming_mode_controller_bench.sv ----
// Purpose: both ends joined, driven over AXI4-Lite
// Assumes: short entry counts, memory acks each request
// Notes: full flash crc walk left out for run time
`timescale 1ns/1ps
`define CHK(a, b) begin checks++; if ((a) !== (b)) begin miscompares++; $display("wrong value at %0t: %h", $time, a); end end
module programming_mode_controller_bench;
	import pmc_pkg::*;
	logic ref_clk = 0, rstn = 0, ce = 1, memAck = 0, memReq, fwSet = 0, intRst = 0;
	logic [7:0] memRdata = 0, s_awaddr = 0, s_araddr = 0;
	logic [16:0] memAddr;
	logic [31:0] s_wdata = 0, s_rdata, rdat;
	logic [3:0] s_wstrb = 0;
	logic s_awvalid = 0, s_wvalid = 0, s_bready = 0, s_arvalid = 0, s_rready = 0;
	logic s_awready, s_wready, s_bvalid, s_arready, s_rvalid;
	logic [1:0] s_bresp, s_rresp, rrsp;
	int miscompares = 0, checks = 0, cyc = 0;
	pmc_link lnk();
	pmc_device #(.ENTRY_CYC(20)) u_pmc_device(.ref_clk, .rstn, .ce, .lnk(lnk),
		.fwAutoProgSet(fwSet), .intRstReq(intRst), .nvProtectIn(3'h0), .nvApmLockIn(1'h1),
		.memReq, .memOp(), .memSpace(), .memAddr, .memWdata(), .memRdata, .memAck, .mode(),
		.progIf(), .cpuRun(), .cpuFetchRam(), .cpuFlashEn(), .nvProtect(), .nvApmLock(),
		.auto_program_flag());
	pmc_programmer #(.HOLD_CYC(24)) u_pmc_programmer(.ref_clk, .rstn, .ce, .lnk(lnk),
		.s_awaddr, .s_awvalid, .s_awready, .s_wdata, .s_wstrb, .s_wvalid, .s_wready, .s_bresp,
		.s_bvalid, .s_bready, .s_araddr, .s_arvalid, .s_arready, .s_rdata, .s_rresp, .s_rvalid,
		.s_rready);
	pmc_link_properties u_pmc_link_properties(.ref_clk, .rstn, .rstnPin(lnk.rstnPin),
		.cmdValid(lnk.cmdValid), .cmdReady(lnk.cmdReady), .cmdIf(lnk.cmdIf), .cmdOp(lnk.cmdOp),
		.cmdSpace(lnk.cmdSpace), .cmdAddr(lnk.cmdAddr), .rspValid(lnk.rspValid), .rspOk(lnk.rspOk));
	// clock; memory stand-in acks one cycle late, data is the low address byte
	always #12.5 ref_clk = ~ref_clk;
	always @(posedge ref_clk) begin
		memAck <= memReq && !memAck;
		memRdata <= memAddr[7:0];
		cyc++;
		if (cyc == 5000) begin
			miscompares++;
			finish_test;
		end
	end
	task finish_test;
		$display("checks %0d miscompares %0d", checks, miscompares);
		if (miscompares == 0 && checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask
	// write: channels offered together, each dropped once taken
	task wr(input logic [7:0] a, input logic [31:0] d);
		logic ta, tw;
		ta = 1'h0;
		tw = 1'h0;
		@(posedge ref_clk);
		{s_awaddr, s_wdata, s_wstrb} <= {a, d, 4'hf};
		{s_awvalid, s_wvalid, s_bready} <= 3'h7;
		while (!(ta && tw)) begin
			@(negedge ref_clk);
			ta |= s_awready;
			tw |= s_wready;
			@(posedge ref_clk);
			s_awvalid <= s_awvalid && !ta;
			s_wvalid <= s_wvalid && !tw;
		end
		do @(negedge ref_clk); while (!s_bvalid);
		@(posedge ref_clk);
		s_bready <= 1'h0;
	endtask
	task rd(input logic [7:0] a);
		logic t;
		@(posedge ref_clk);
		s_araddr <= a;
		{s_arvalid, s_rready} <= 2'h3;
		do begin
			@(negedge ref_clk);
			t = s_arready;
			@(posedge ref_clk);
		end while (!t);
		s_arvalid <= 1'h0;
		do @(negedge ref_clk); while (!s_rvalid);
		{rdat, rrsp} = {s_rdata, s_rresp};
		@(posedge ref_clk);
		s_rready <= 1'h0;
	endtask
	// launch one command, poll until not busy; polls bounded so dropped ones return
	task cmd(input logic [7:0] op, input logic [2:0] sp, input logic [1:0] fi,
		input logic [16:0] ad, input logic [7:0] d);
		wr(REG_ADDR, {15'h0, ad});
		wr(REG_DATA, {24'h0, d});
		wr(REG_CMD, {18'h0, fi, 1'h0, sp, op});
		rdat = 32'h2;
		repeat (8) if (rdat[STAT_BUSY]) rd(REG_STATUS);
	endtask
	// pin action, one frozen cycle, wait for pin release
	task pin(input logic [31:0] c);
		wr(REG_CTRL, c);
		ce <= 1'h0;
		@(posedge ref_clk);
		ce <= 1'h1;
		rdat = 32'h1;
		repeat (40) if (rdat[STAT_HOLD]) rd(REG_STATUS);
	endtask
	task t_short;
		pin(32'h2);
		cmd(OP_ENABLE, SP_FLASH, IF_SPI, 17'h0, 8'h0);
		`CHK(rdat[STAT_BUSY], 1'h1)
		wr(REG_CTRL, 32'h4);
	endtask
	task t_enter;
		pin(32'h1);
		cmd(OP_ENABLE, SP_FLASH, IF_SPI, 17'h0, 8'h0);
		`CHK(rdat[2:1], 2'h2)
	endtask
	task t_mem;
		cmd(OP_WRITE, SP_XRAM12, IF_SPI, 17'h02fff, 8'h5a);
		`CHK(rdat[2:1], 2'h2)
		cmd(OP_READ, SP_XRAM12, IF_SPI, 17'h02fff, 8'h0);
		rd(REG_RSP);
		`CHK(rdat, 32'hff)
		cmd(OP_READ, SP_XRAM12, IF_SPI, 17'h03000, 8'h0);
		`CHK(rdat[2:1], 2'h0)
		cmd(OP_ERASE_SECTOR, SP_FLASH, IF_SPI, 17'h0003f, 8'h0);
		`CHK(rdat[2:1], 2'h2)
		cmd(OP_PROG_SECTOR, SP_FLASH, IF_SPI, 17'h0, 8'h0);
		`CHK(rdat[2:1], 2'h2)
		cmd(OP_WRITE, SP_CFG, IF_SPI, 17'h0ff, 8'h3c);
		`CHK(rdat[2:1], 2'h2)
	endtask
	task t_deny;
		cmd(OP_READ, SP_INTERNAL_DATA_RAM, IF_SPI, 17'h0, 8'h0);
		`CHK(rdat[2:1], 2'h0)
		cmd(OP_READ, SP_CRIT, IF_SPI, 17'h0, 8'h0);
		`CHK(rdat[2:1], 2'h0)
	endtask
	task t_other;
		cmd(OP_READ_SIG, SP_FLASH, IF_UART, 17'h0, 8'h0);
		`CHK(rdat[STAT_BUSY], 1'h1)
		wr(REG_CTRL, 32'h4);
		cmd(OP_READ_SIG, SP_FLASH, IF_SPI, 17'h0, 8'h0);
		rd(REG_RSP);
		`CHK(rdat, {24'h0, SIG_DEFAULT[55:48]})
		rd(8'h18);
		`CHK(rrsp, AXI_SLVERR)
	endtask
	task t_lock;
		cmd(OP_READ, SP_FLASH, IF_SPI, 17'h5, 8'h0);
		`CHK(rdat[2:1], 2'h2)
		cmd(OP_SET_LOCK, SP_CFG, IF_SPI, 17'h0, 8'h7);
		cmd(OP_READ, SP_FLASH, IF_SPI, 17'h5, 8'h0);
		`CHK(rdat[2:1], 2'h0)
		cmd(OP_EXEC_RAM, SP_XRAM4, IF_SPI, 17'h0, 8'h0);
		`CHK(rdat[2:1], 2'h0)
		cmd(OP_ERASE_SECTOR, SP_FLASH, IF_SPI, 17'h1, 8'h0);
		`CHK(rdat[2:1], 2'h0)
	endtask
	initial begin
		repeat (12) @(posedge ref_clk);
		rstn <= 1'h1;
		t_short;
		t_enter;
		t_mem;
		t_deny;
		t_other;
		t_lock;
		finish_test;
	end
endmodule
